//--- hdl/ucs_pkg.sv
// package: register map, field layout, reset values and timing of the bank
`default_nettype none
package ucs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // register offsets
  localparam logic [2:0] OFS_CONV_SYNC  = 3'h0;
  localparam logic [2:0] OFS_DROP_GAIN  = 3'h1;
  localparam logic [2:0] OFS_CUR_LIMIT  = 3'h2;
  localparam logic [2:0] OFS_RETRY_DET  = 3'h3;
  localparam logic [2:0] OFS_SETUP_DONE = 3'h4;
  // field positions
  localparam int POS_RUN_BIT   = 5;
  localparam int POS_SYNC_DIR  = 1;
  localparam int POS_SS_EN     = 0;
  localparam int POS_TRIP      = 4;
  localparam int POS_DONE      = 0;
  localparam int POS_UNCONF    = 7;
  // reset values
  localparam logic       RST_RUN_BIT = 1'h1;
  localparam logic [4:0] RST_GAIN    = 5'h00;
  localparam logic [1:0] RST_DEB     = 2'h0;
  localparam logic       RST_TRIP    = 1'h0;
  localparam logic [2:0] RST_LIMIT   = 3'h7;
  localparam logic [1:0] RST_RETRY   = 2'h0;
  localparam logic       RST_DONE    = 1'h0;
  // readback masks of implemented bits
  localparam logic [7:0] MSK_CONV  = 8'h23;
  localparam logic [7:0] MSK_GAIN  = 8'h1f;
  localparam logic [7:0] MSK_LIMIT = 8'hd7;
  localparam logic [7:0] MSK_RETRY = 8'hf0;
  localparam logic [7:0] MSK_DONE  = 8'h01;
  // charge detect, debounce and current limit codes
  localparam logic [1:0] CD_PASS_SDP = 2'h0;
  localparam logic [1:0] CD_AUTO_CDP = 2'h1;
  localparam logic [1:0] DEB_NONE    = 2'h3;
  localparam logic [2:0] LIM_TOP     = 3'h4;
  // times in microseconds
  localparam int unsigned FAULT_US = 16_000;
  localparam int unsigned DEB0_US  = 1_100;
  localparam int unsigned DEB1_US  = 5_500;
  localparam int unsigned DEB2_US  = 11_000;
  localparam int unsigned RTY0_US  = 2_000_000;
  localparam int unsigned RTY1_US  = 1_000_000;
  localparam int unsigned RTY2_US  = 500_000;
  localparam int unsigned RTY3_US  = 16_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  typedef struct packed {
    logic       run_bit;
    logic       sync_dir;
    logic       ss_en;
    logic [4:0] gain;
    logic [1:0] deb;
    logic       trip;
    logic [2:0] limit;
    logic [1:0] retry;
    logic [1:0] cd;
    logic       done;
  } ucs_cfg_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ucs_req_type;
endpackage
`default_nettype wire

//--- hdl/ucs_fault_timer.sv
// fault debounce and retry timer for the overcurrent with undervoltage fault
`default_nettype none
module ucs_fault_timer #(
  parameter int unsigned FAULT_CYC = 800_000,
  parameter int unsigned RTY0_CYC  = 100_000_000,
  parameter int unsigned RTY1_CYC  = 50_000_000,
  parameter int unsigned RTY2_CYC  = 25_000_000,
  parameter int unsigned RTY3_CYC  = 800_000
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cond,
  input  wire logic       i_armed,
  input  wire logic [1:0] i_retry,
  output logic            o_fault,
  output logic            o_shutdown
);
  typedef enum logic [1:0] {ST_IDLE, ST_DEB, ST_OFF} ucs_ft_type;
  ucs_ft_type  st_q;
  logic [31:0] cnt_q;
  logic [31:0] rty_cyc;

  assign rty_cyc = (i_retry == 2'h0) ? 32'(RTY0_CYC) :
                   (i_retry == 2'h1) ? 32'(RTY1_CYC) :
                   (i_retry == 2'h2) ? 32'(RTY2_CYC) : 32'(RTY3_CYC);

  // **************************************************
  // sequence: debounce, shut down, retry
  // **************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q  <= ST_IDLE;
      cnt_q <= 32'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 32'h0;
          if (i_cond && i_armed) begin
            st_q <= ST_DEB;
          end
        end
        ST_DEB: begin
          // condition must persist without a break
          if (!i_cond || !i_armed) begin
            st_q <= ST_IDLE;
          end else if (cnt_q >= 32'(FAULT_CYC) - 32'h1) begin
            st_q  <= ST_OFF;
            cnt_q <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_OFF: begin
          // retry period taken live, so a rewrite shortens or lengthens a running wait
          if (cnt_q >= rty_cyc - 32'h1) begin
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign o_fault    = (st_q == ST_OFF);
  assign o_shutdown = (st_q == ST_OFF);

  fault_needs_time_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_fault) |-> $past(i_cond, 2))
    else $error("fault rose without a persisting condition");
  disarm_no_fault_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_armed && st_q != ST_OFF) |=> !$rose(o_fault))
    else $error("fault raised while trip select disables it");
endmodule
`default_nettype wire

//--- hdl/ucs_setup_regs.sv
// setup register bank of the usb charger converter
`default_nettype none
module ucs_setup_regs #(
  parameter logic        VARIANT_AUTO_CDP = 1'h0,
  parameter int unsigned FAULT_CYC = ucs_pkg::FAULT_US * ucs_pkg::CYC_PER_US,
  parameter int unsigned RTY0_CYC  = ucs_pkg::RTY0_US * ucs_pkg::CYC_PER_US,
  parameter int unsigned RTY1_CYC  = ucs_pkg::RTY1_US * ucs_pkg::CYC_PER_US,
  parameter int unsigned RTY2_CYC  = ucs_pkg::RTY2_US * ucs_pkg::CYC_PER_US,
  parameter int unsigned RTY3_CYC  = ucs_pkg::RTY3_US * ucs_pkg::CYC_PER_US,
  parameter int unsigned DEB0_CYC  = ucs_pkg::DEB0_US * ucs_pkg::CYC_PER_US,
  parameter int unsigned DEB1_CYC  = ucs_pkg::DEB1_US * ucs_pkg::CYC_PER_US,
  parameter int unsigned DEB2_CYC  = ucs_pkg::DEB2_US * ucs_pkg::CYC_PER_US
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire ucs_pkg::ucs_req_type i_req,
  output logic [7:0]             o_rdata,
  output logic [7:0]             o_unconf_flags,
  input  wire logic              i_converter_run_pin,
  input  wire logic              i_first_strap_resistor,
  input  wire logic              i_data_mode_pin,
  input  wire logic              i_overcurrent,
  input  wire logic              i_undervolt,
  output logic                   o_converter_on,
  output logic                   o_sync_oe_n,
  output logic                   o_fault,
  output logic                   o_limit_exceeded,
  output ucs_pkg::ucs_cfg_type   o_cfg
);
  // **************************************************
  // pin synchronisers
  // **************************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  wire  [4:0] pins_raw = {i_converter_run_pin, i_first_strap_resistor,
                          i_data_mode_pin, i_overcurrent, i_undervolt};
  wire        run_pin_s = sync2_q[4];
  wire        strap_s   = sync2_q[3];
  wire        dmode_s   = sync2_q[2];
  wire        oc_s      = sync2_q[1];
  wire        uv_s      = sync2_q[0];

  always_ff @(posedge i_clk) begin
    sync1_q <= pins_raw;
    sync2_q <= sync1_q;
  end

  // **************************************************
  // strap capture after reset release
  // **************************************************
  // straps must settle through the synchroniser, so loading waits two edges
  logic [1:0] strap_cnt_q;
  logic       strap_load;
  assign strap_load = (strap_cnt_q == 2'h2);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // **************************************************
  // register file
  // **************************************************
  ucs_pkg::ucs_cfg_type cfg_q;
  wire [7:0] wd = i_req.wdata;
  wire wr_conv  = i_req.wr && (i_req.addr == ucs_pkg::OFS_CONV_SYNC);
  wire wr_gain  = i_req.wr && (i_req.addr == ucs_pkg::OFS_DROP_GAIN);
  wire wr_limit = i_req.wr && (i_req.addr == ucs_pkg::OFS_CUR_LIMIT);
  wire wr_retry = i_req.wr && (i_req.addr == ucs_pkg::OFS_RETRY_DET);
  wire wr_done  = i_req.wr && (i_req.addr == ucs_pkg::OFS_SETUP_DONE);
  wire [1:0] cd_preload = (VARIANT_AUTO_CDP && dmode_s) ?
                          ucs_pkg::CD_AUTO_CDP : ucs_pkg::CD_PASS_SDP;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_q.run_bit  <= ucs_pkg::RST_RUN_BIT;
      cfg_q.sync_dir <= 1'h0;
      cfg_q.ss_en    <= 1'h0;
      cfg_q.gain     <= ucs_pkg::RST_GAIN;
      cfg_q.deb      <= ucs_pkg::RST_DEB;
      cfg_q.trip     <= ucs_pkg::RST_TRIP;
      cfg_q.limit    <= ucs_pkg::RST_LIMIT;
      cfg_q.retry    <= ucs_pkg::RST_RETRY;
      cfg_q.cd       <= ucs_pkg::CD_PASS_SDP;
      cfg_q.done     <= ucs_pkg::RST_DONE;
    end else begin
      if (strap_load) begin
        cfg_q.sync_dir <= strap_s;
        cfg_q.ss_en    <= strap_s;
        cfg_q.cd       <= cd_preload;
      end
      // only implemented bits are taken from a write
      if (wr_conv) begin
        cfg_q.run_bit  <= wd[ucs_pkg::POS_RUN_BIT];
        cfg_q.sync_dir <= wd[ucs_pkg::POS_SYNC_DIR];
        cfg_q.ss_en    <= wd[ucs_pkg::POS_SS_EN];
      end
      if (wr_gain) begin
        cfg_q.gain <= wd[4:0];
      end
      if (wr_limit) begin
        cfg_q.deb   <= wd[7:6];
        cfg_q.trip  <= wd[ucs_pkg::POS_TRIP];
        cfg_q.limit <= wd[2:0];
      end
      if (wr_retry) begin
        cfg_q.retry <= wd[7:6];
        cfg_q.cd    <= wd[5:4];
      end
      if (wr_done) begin
        cfg_q.done <= wd[ucs_pkg::POS_DONE];
      end
    end
  end

  // **************************************************
  // read path
  // **************************************************
  wire [7:0] rd_conv  = {2'h0, cfg_q.run_bit, 3'h0, cfg_q.sync_dir,
                         cfg_q.ss_en} & ucs_pkg::MSK_CONV;
  wire [7:0] rd_gain  = {3'h0, cfg_q.gain} & ucs_pkg::MSK_GAIN;
  wire [7:0] rd_limit = {cfg_q.deb, 1'h0, cfg_q.trip, 1'h0, cfg_q.limit}
                        & ucs_pkg::MSK_LIMIT;
  wire [7:0] rd_retry = {cfg_q.retry, cfg_q.cd, 4'h0} & ucs_pkg::MSK_RETRY;
  wire [7:0] rd_done  = {7'h0, cfg_q.done} & ucs_pkg::MSK_DONE;
  wire [7:0] rd_mux;
  assign rd_mux =
    (i_req.addr == ucs_pkg::OFS_CONV_SYNC)  ? rd_conv  :
    (i_req.addr == ucs_pkg::OFS_DROP_GAIN)  ? rd_gain  :
    (i_req.addr == ucs_pkg::OFS_CUR_LIMIT)  ? rd_limit :
    (i_req.addr == ucs_pkg::OFS_RETRY_DET)  ? rd_retry :
    (i_req.addr == ucs_pkg::OFS_SETUP_DONE) ? rd_done  : 8'h00;

  // bits that exist at an address; every other position reads zero
  function automatic logic [7:0] used_bits(input logic [2:0] a);
    logic [7:0] m;
    m = 8'h00;
    if (a == ucs_pkg::OFS_CONV_SYNC) begin
      m = ucs_pkg::MSK_CONV;
    end else if (a == ucs_pkg::OFS_DROP_GAIN) begin
      m = ucs_pkg::MSK_GAIN;
    end else if (a == ucs_pkg::OFS_CUR_LIMIT) begin
      m = ucs_pkg::MSK_LIMIT;
    end else if (a == ucs_pkg::OFS_RETRY_DET) begin
      m = ucs_pkg::MSK_RETRY;
    end else if (a == ucs_pkg::OFS_SETUP_DONE) begin
      m = ucs_pkg::MSK_DONE;
    end
    return m;
  endfunction

  logic [7:0] rdata_q;
  logic [7:0] unconf_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q  <= 8'h00;
      unconf_q <= 8'h80;
    end else begin
      if (i_req.rd) begin
        rdata_q <= rd_mux;
      end
      // flag follows the done bit directly, so it cannot be lost
      unconf_q <= {!cfg_q.done, 7'h0};
    end
  end
  assign o_rdata        = rdata_q;
  assign o_unconf_flags = unconf_q;

  // **************************************************
  // current limit debounce
  // **************************************************
  // threshold compare sits in the analogue front end; this times its report
  logic [31:0] deb_cnt_q;
  logic [31:0] deb_cyc;
  logic        lim_q;
  assign deb_cyc = (cfg_q.deb == 2'h0) ? 32'(DEB0_CYC) :
                   (cfg_q.deb == 2'h1) ? 32'(DEB1_CYC) :
                   (cfg_q.deb == 2'h2) ? 32'(DEB2_CYC) : 32'h0;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !oc_s) begin
      deb_cnt_q <= 32'h0;
      lim_q     <= 1'h0;
    end else if (cfg_q.deb == ucs_pkg::DEB_NONE ||
                 deb_cnt_q >= deb_cyc - 32'h1) begin
      lim_q <= 1'h1;
    end else begin
      deb_cnt_q <= deb_cnt_q + 32'h1;
    end
  end
  assign o_limit_exceeded = lim_q;

  // **************************************************
  // fault and converter enable
  // **************************************************
  logic shutdown;
  logic fault_w;
  ucs_fault_timer #(
    .FAULT_CYC (FAULT_CYC),
    .RTY0_CYC  (RTY0_CYC),
    .RTY1_CYC  (RTY1_CYC),
    .RTY2_CYC  (RTY2_CYC),
    .RTY3_CYC  (RTY3_CYC)
  ) u_fault (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_cond     (oc_s && uv_s),
    .i_armed    (!cfg_q.trip),
    .i_retry    (cfg_q.retry),
    .o_fault    (fault_w),
    .o_shutdown (shutdown)
  );

  logic on_q;
  logic fault_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      on_q    <= 1'h0;
      fault_q <= 1'h0;
    end else begin
      on_q    <= cfg_q.run_bit && run_pin_s && cfg_q.done && !shutdown;
      fault_q <= fault_w;
    end
  end
  assign o_converter_on = on_q;
  assign o_sync_oe_n    = cfg_q.sync_dir;
  assign o_fault        = fault_q;
  assign o_cfg          = cfg_q;

  held_until_done_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !cfg_q.done |=> !o_converter_on)
    else $error("converter on before setup done");
  run_and_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_converter_on |-> $past(cfg_q.run_bit) && $past(run_pin_s))
    else $error("converter on without run bit and pin");
  unconf_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !cfg_q.done |=> o_unconf_flags[ucs_pkg::POS_UNCONF])
    else $error("unconfigured flag low while not configured");
  unused_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_req.rd |=> (o_rdata & ~used_bits($past(i_req.addr))) == 8'h00)
    else $error("unused bit read as one");
  gain_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_gain |=> cfg_q.gain == $past(wd[4:0]))
    else $error("gain write lost");
  limit_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_limit |=> cfg_q.limit == $past(wd[2:0])
      && cfg_q.trip == $past(wd[ucs_pkg::POS_TRIP]))
    else $error("limit write lost");
  shutdown_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    shutdown |=> !o_converter_on)
    else $error("converter on during fault shutdown");
  sync_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_conv |=> o_sync_oe_n == $past(wd[ucs_pkg::POS_SYNC_DIR]))
    else $error("sync direction write not applied");
endmodule
`default_nettype wire

//--- testbench/test_ucs_setup_regs.sv
// self-checking bench for the usb charger setup register bank
`default_nettype none
module test_ucs_setup_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // shortened counts so the fault and retry paths finish quickly
  // ****************************************************************
  localparam int unsigned FLT   = 20;
  localparam int unsigned RT3   = 10;
  localparam int unsigned DB0   = 30;
  localparam int          M_ON  = 3;
  localparam int          M_FLT = 2;
  localparam int          M_LIM = 1;
  localparam int          M_OEN = 0;
  logic                 i_clk;
  logic                 i_rst_n;
  ucs_pkg::ucs_req_type req;
  logic [7:0]           rdata;
  logic [7:0]           unconf;
  logic                 run_pin;
  logic                 strap;
  logic                 dmode;
  logic                 oc;
  logic                 uv;
  logic                 conv_on;
  logic                 sync_oe_n;
  logic                 fault;
  logic                 lim_exc;
  ucs_pkg::ucs_cfg_type cfg;
  int                   fail_count;
  int                   checked;
  logic [7:0]           msk [8];
  wire logic [3:0]      mon = {conv_on, fault, lim_exc, sync_oe_n};

  ucs_setup_regs #(
    .VARIANT_AUTO_CDP (1'h1),
    .FAULT_CYC (FLT),
    .RTY0_CYC  (40),
    .RTY1_CYC  (30),
    .RTY2_CYC  (20),
    .RTY3_CYC  (RT3),
    .DEB0_CYC  (DB0),
    .DEB1_CYC  (20),
    .DEB2_CYC  (10)
  ) i_dut (
    .i_clk                  (i_clk),
    .i_rst_n                (i_rst_n),
    .i_req                  (req),
    .o_rdata                (rdata),
    .o_unconf_flags         (unconf),
    .i_converter_run_pin    (run_pin),
    .i_first_strap_resistor (strap),
    .i_data_mode_pin        (dmode),
    .i_overcurrent          (oc),
    .i_undervolt            (uv),
    .o_converter_on         (conv_on),
    .o_sync_oe_n            (sync_oe_n),
    .o_fault                (fault),
    .o_limit_exceeded       (lim_exc),
    .o_cfg                  (cfg)
  );

  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;

  // ****************************************************************
  // access tasks and comparisons
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge i_clk);
    req.wr <= 1'b0;
  endtask

  // rdata holds until the next read, so sampling one edge late is safe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge i_clk);
    req.rd <= 1'b0;
    @(posedge i_clk);
    #1;
    check("read data", exp, rdata);
  endtask

  // waits a bounded number of cycles for an output to reach a level
  task automatic await(input string what, input int idx, input logic lvl,
                       input int n);
    int c;
    c = 0;
    #1;
    while (mon[idx] !== lvl && c < n) begin
      @(posedge i_clk);
      #1;
      c++;
    end
    check(what, {7'h00, lvl}, {7'h00, mon[idx]});
  endtask

  // an output must keep its level for n whole cycles
  task automatic hold(input string what, input int idx, input logic lvl,
                      input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      if (mon[idx] !== lvl) bad = 1'b1;
    end
    check(what, 8'h00, {7'h00, bad});
  endtask

  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    end_of_test();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    i_rst_n = 1'b0;
    req = '0;
    run_pin = 1'b0;
    strap = 1'b1;
    dmode = 1'b1;
    oc = 1'b0;
    uv = 1'b0;
    fail_count = 0;
    checked = 0;
    msk = '{ucs_pkg::MSK_CONV, ucs_pkg::MSK_GAIN, ucs_pkg::MSK_LIMIT,
            ucs_pkg::MSK_RETRY, ucs_pkg::MSK_DONE, 8'h00, 8'h00, 8'h00};
    do_reset();
    check("unconfigured", 8'h80, unconf);
    check("converter on", 8'h00, {7'h00, conv_on});
    check("sync oe_n", 8'h01, {7'h00, sync_oe_n});
    rd(ucs_pkg::OFS_CONV_SYNC, 8'h23);
    rd(ucs_pkg::OFS_DROP_GAIN, 8'h00);
    rd(ucs_pkg::OFS_CUR_LIMIT, 8'h07);
    rd(ucs_pkg::OFS_RETRY_DET, 8'h10);
    rd(ucs_pkg::OFS_SETUP_DONE, 8'h00);
    // unused bits and unmapped addresses
    for (int a = 0; a < 8; a++) begin
      wr(3'(a), 8'hff);
      rd(3'(a), msk[a]);
      if (a == 4) check("unconfigured", 8'h00, unconf);
      wr(3'(a), 8'h00);
      rd(3'(a), 8'h00);
    end
    check("unconfigured", 8'h80, unconf);
    await("sync oe_n", M_OEN, 1'b0, 2);
    // every gain code lands in the field unchanged
    for (int g = 0; g < 32; g++) begin
      wr(ucs_pkg::OFS_DROP_GAIN, 8'(g));
      @(posedge i_clk);
      #1;
      check("gain", 8'(g), {3'h0, cfg.gain});
    end
    // converter enable is the and of bit, pin, setup done and no fault shutdown
    run_pin <= 1'b1;
    wr(ucs_pkg::OFS_CONV_SYNC, 8'h20);
    hold("held off", M_ON, 1'b0, 10);
    wr(ucs_pkg::OFS_SETUP_DONE, 8'h01);
    await("converter on", M_ON, 1'b1, 8);
    wr(ucs_pkg::OFS_CONV_SYNC, 8'h00);
    await("bit off", M_ON, 1'b0, 8);
    wr(ucs_pkg::OFS_CONV_SYNC, 8'h20);
    await("bit on", M_ON, 1'b1, 8);
    run_pin <= 1'b0;
    await("pin off", M_ON, 1'b0, 8);
    run_pin <= 1'b1;
    await("pin on", M_ON, 1'b1, 8);
    // debounce: code 11 is immediate, code 00 waits its count
    wr(ucs_pkg::OFS_CUR_LIMIT, 8'hc7);
    oc <= 1'b1;
    await("no debounce", M_LIM, 1'b1, 6);
    oc <= 1'b0;
    await("limit clear", M_LIM, 1'b0, DB0 + 10);
    wr(ucs_pkg::OFS_CUR_LIMIT, 8'h07);
    oc <= 1'b1;
    hold("debounce wait", M_LIM, 1'b0, DB0 - 2);
    await("debounced", M_LIM, 1'b1, 12);
    oc <= 1'b0;
    await("limit clear", M_LIM, 1'b0, DB0 + 10);
    // combined fault with the shortest retry period
    wr(ucs_pkg::OFS_RETRY_DET, 8'hc0);
    oc <= 1'b1;
    uv <= 1'b1;
    hold("fault wait", M_FLT, 1'b0, FLT - 2);
    await("fault set", M_FLT, 1'b1, 12);
    await("shutdown", M_ON, 1'b0, 3);
    oc <= 1'b0;
    uv <= 1'b0;
    hold("retry hold", M_FLT, 1'b1, RT3 - 5);
    await("retry end", M_FLT, 1'b0, 14);
    await("restart", M_ON, 1'b1, 6);
    // trip bit set: the combined fault is ignored
    wr(ucs_pkg::OFS_CUR_LIMIT, 8'h17);
    oc <= 1'b1;
    uv <= 1'b1;
    hold("trip off", M_FLT, 1'b0, FLT + 10);
    check("still on", 8'h01, {7'h00, conv_on});
    oc <= 1'b0;
    uv <= 1'b0;
    // second reset with the strap low
    strap <= 1'b0;
    dmode <= 1'b0;
    do_reset();
    check("unconfigured", 8'h80, unconf);
    rd(ucs_pkg::OFS_CONV_SYNC, 8'h20);
    rd(ucs_pkg::OFS_RETRY_DET, 8'h00);
    rd(ucs_pkg::OFS_SETUP_DONE, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
